// [src/wdl_counter.sv]
`timescale 1ns/1ps
module wdl_counter #(
  parameter int CNT_W = 17
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic restart,
  input wire logic advance,
  input wire logic [CNT_W-1:0] limit,
  output logic expired
);

  logic [CNT_W-1:0] count;

  always_ff @(posedge clk)
  begin
    if (reset || restart)
    begin
      count <= '0;
      expired <= 1'b0;
    end
    else if (advance && (count >= limit - 1'b1))
    begin
      count <= '0;
      expired <= 1'b1;
    end
    else
    begin
      expired <= 1'b0;
      if (advance)
        count <= count + 1'b1;
    end
  end

endmodule // wdl_counter

// [src/wdl_pkg.sv]
package wdl_pkg;

  // ---------------------------------------------------------------
  // Clock and bus
  // ---------------------------------------------------------------
  localparam int CLK_MHZ = 20;
  localparam int WB_AW = 8;
  localparam int WB_DW = 32;

  // ---------------------------------------------------------------
  // Register word indexes (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [5:0] MODE_IDX = 6'h0f;
  localparam logic [5:0] STATUS_IDX = 6'h10;
  localparam logic [5:0] IRQ_STAT_IDX = 6'h11;
  localparam logic [5:0] IRQ_MASK_IDX = 6'h12;
  localparam int IDX_LSB = 2;

  // ---------------------------------------------------------------
  // Mode register layout and reset value
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [2:0] spare;
    logic srcXtal;
    logic runStop;
    logic runHalt;
    logic [1:0] timeSel;
  } wdl_mode_t;

  localparam logic [7:0] MODE_RESET = 8'h0e;
  localparam int MODE_W = 8;

  // ---------------------------------------------------------------
  // Timeouts
  // ---------------------------------------------------------------
  localparam int SCLK_TIMEOUT_0 = 128;
  localparam int SCLK_TIMEOUT_1 = 256;
  localparam int SCLK_TIMEOUT_2 = 512;
  localparam int SCLK_TIMEOUT_3 = 2048;
  localparam real RC_TIMEOUT_MS_0 = 3.5;
  localparam real RC_TIMEOUT_MS_1 = 7.0;
  localparam real RC_TIMEOUT_MS_2 = 14.0;
  localparam real RC_TIMEOUT_MS_3 = 56.0;
  localparam int RC_FREQ_KHZ_DEFAULT = 1000;
  localparam int WINDOW_CYCLES = 60;
  localparam int POR_TIME_US = 5000;
  localparam int CNT_W = 17;
  localparam int POR_W = 20;
  localparam int WIN_W = 6;

  // ---------------------------------------------------------------
  // Event and status bit positions
  // ---------------------------------------------------------------
  localparam int EV_W = 3;
  localparam int EV_TIMEOUT = 0;
  localparam int EV_LOWV = 1;
  localparam int EV_REFUSED = 2;
  localparam int ST_ENABLED = 0;
  localparam int ST_WINDOW = 1;
  localparam int ST_LOCKED = 2;
  localparam int ST_LOWV = 3;
  localparam int ST_POR = 4;
  localparam int ST_XTAL = 5;

  typedef enum logic [1:0] {WIN_WAIT, WIN_OPEN, WIN_LOCKED} wdl_win_t;

endpackage

// [src/wdl_sync.sv]
`timescale 1ns/1ps
module wdl_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [W-1:0] async,
  output logic [W-1:0] synced
);

  logic [W-1:0] stage1;

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      stage1 <= '0;
      synced <= '0;
    end
    else
    begin
      stage1 <= async;
      synced <= stage1;
    end
  end

endmodule // wdl_sync

// [src/wdl_top.sv]
// Operation
// - On the crystal clock the four time codes give 128, 256, 512 and 2048 clock cycles.
// - On the RC clock the four time codes give at least 3.5, 7, 14 and 56 ms.
// - After reset the time code is the default one, code 2, of at least 14 ms.
// - Mode bit 2 keeps the counter running in HALT and resets to one.
// - Mode bit 3 keeps it running in STOP, resets to one, and needs the RC source.
// - A permanent watchdog on the RC source runs in every mode and cannot be stopped.
// - Mode bit 4 picks the crystal input as counter clock, zero picks the RC.
// - Mode writes count only in the 60 cycles after the first instruction past a reset.
// - The mode register is write only and lives at index 0x0f.
// - With the permanent option the watchdog runs on leaving any reset.
// - The refresh instruction restarts the timeout from its start.
// - Without that option only a refresh starts it and every reset disables it.
// - Global reset is held while the supply is below the trip level.
// - Power-on and watchdog resets drive the reset pin low for the power-on time.
// - Stop recovery and a watchdog reset out of STOP keep the mode register.
`timescale 1ns/1ps
module wdl_top #(
  parameter bit PERMANENT_WDT = 1'b0,
  parameter int RC_FREQ_KHZ = wdl_pkg::RC_FREQ_KHZ_DEFAULT,
  parameter int RC_TICKS_0 = int'($ceil(wdl_pkg::RC_TIMEOUT_MS_0 * RC_FREQ_KHZ)),
  parameter int RC_TICKS_1 = int'($ceil(wdl_pkg::RC_TIMEOUT_MS_1 * RC_FREQ_KHZ)),
  parameter int RC_TICKS_2 = int'($ceil(wdl_pkg::RC_TIMEOUT_MS_2 * RC_FREQ_KHZ)),
  parameter int RC_TICKS_3 = int'($ceil(wdl_pkg::RC_TIMEOUT_MS_3 * RC_FREQ_KHZ)),
  parameter int POR_CYCLES = wdl_pkg::POR_TIME_US * wdl_pkg::CLK_MHZ
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [wdl_pkg::WB_AW-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [wdl_pkg::WB_DW-1:0] dat_i,
  output logic [wdl_pkg::WB_DW-1:0] dat_o,
  output logic ack_o,
  input wire logic refreshStrobe,
  input wire logic firstInstr,
  input wire logic stopRecovery,
  input wire logic haltMode,
  input wire logic stopMode,
  input wire logic rcClk,
  input wire logic lowVoltage,
  input wire logic resetPinIn,
  output logic resetPinOut,
  output logic resetPinOe,
  output logic globalReset,
  output logic irq
);

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic rcSync;
  logic lowSync;
  logic pinSync;
  logic rcPrev;
  logic rcTick;

  wdl_sync #(
    .W(3)
  ) u_sync (
    .clk(clk),
    .reset(reset),
    .async({rcClk, lowVoltage, resetPinIn}),
    .synced({rcSync, lowSync, pinSync})
  );

  always_ff @(posedge clk)
  begin
    if (reset)
      rcPrev <= 1'b0;
    else
      rcPrev <= rcSync;
  end

  assign rcTick = rcSync && !rcPrev;

  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------
  logic busReq;
  logic busWrite;
  logic [5:0] wordIdx;
  logic writeMode;
  logic writeIrqStat;
  logic writeIrqMask;

  assign busReq = cyc_i && stb_i;
  assign busWrite = busReq && we_i && ack_o;
  assign wordIdx = adr_i[wdl_pkg::WB_AW-1:wdl_pkg::IDX_LSB];
  assign writeMode = busWrite && sel_i[0] && (wordIdx == wdl_pkg::MODE_IDX);
  assign writeIrqStat = busWrite && sel_i[0] && (wordIdx == wdl_pkg::IRQ_STAT_IDX);
  assign writeIrqMask = busWrite && sel_i[0] && (wordIdx == wdl_pkg::IRQ_MASK_IDX);

  // ---------------------------------------------------------------
  // Reset sources
  // ---------------------------------------------------------------
  logic wdtExpired;
  logic extReset;
  logic porCountBusy;
  logic [wdl_pkg::POR_W-1:0] porCount;
  logic wdtFromStop;
  logic restoreMode;
  logic anyReset;
  logic [1:0] oeHist;

  // Pin lags the released drive by two sync stages
  assign extReset = !pinSync && !resetPinOe && !(|oeHist);
  assign porCountBusy = (porCount != '0);
  assign wdtFromStop = wdtExpired && stopMode;
  assign restoreMode = (wdtExpired && !wdtFromStop) || lowSync || extReset;
  assign anyReset = wdtExpired || lowSync || extReset || stopRecovery;

  // Power-on time for reset and watchdog reset
  always_ff @(posedge clk)
  begin
    if (reset)
      porCount <= wdl_pkg::POR_W'(POR_CYCLES);
    else if (wdtExpired)
      porCount <= wdl_pkg::POR_W'(POR_CYCLES);
    else if (porCountBusy)
      porCount <= porCount - 1'b1;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      resetPinOut <= 1'b0;
      resetPinOe <= 1'b1;
      oeHist <= '1;
      globalReset <= 1'b1;
    end
    else
    begin
      resetPinOut <= 1'b0;
      resetPinOe <= porCountBusy || wdtExpired;
      oeHist <= {oeHist[0], resetPinOe};
      globalReset <= porCountBusy || wdtExpired || lowSync || extReset;
    end
  end

  // ---------------------------------------------------------------
  // Mode register and write window
  // ---------------------------------------------------------------
  wdl_pkg::wdl_mode_t mode;
  wdl_pkg::wdl_win_t winState;
  logic [wdl_pkg::WIN_W-1:0] winCount;
  logic modeRefused;
  logic modeAccepted;

  assign modeRefused = writeMode && (winState != wdl_pkg::WIN_OPEN);
  assign modeAccepted = writeMode && (winState == wdl_pkg::WIN_OPEN);

  always_ff @(posedge clk)
  begin
    if (reset)
      mode <= wdl_pkg::MODE_RESET;
    else if (restoreMode)
      mode <= wdl_pkg::MODE_RESET;
    else if (modeAccepted)
      mode <= dat_i[wdl_pkg::MODE_W-1:0];
  end

  always_ff @(posedge clk)
  begin
    if (reset || anyReset || globalReset)
    begin
      winState <= wdl_pkg::WIN_WAIT;
      winCount <= '0;
    end
    else
    begin
      unique case (winState)
        wdl_pkg::WIN_WAIT:
        begin
          if (firstInstr)
          begin
            winState <= wdl_pkg::WIN_OPEN;
            winCount <= '0;
          end
        end
        wdl_pkg::WIN_OPEN:
        begin
          if (winCount == wdl_pkg::WIN_W'(wdl_pkg::WINDOW_CYCLES - 1))
            winState <= wdl_pkg::WIN_LOCKED;
          winCount <= winCount + 1'b1;
        end
        wdl_pkg::WIN_LOCKED:
          winState <= wdl_pkg::WIN_LOCKED;
        default:
          winState <= wdl_pkg::WIN_LOCKED;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Watchdog enable and counting
  // ---------------------------------------------------------------
  logic enabled;
  logic rcSource;
  logic modeAllows;
  logic advance;
  logic [wdl_pkg::CNT_W-1:0] limit;
  logic [wdl_pkg::CNT_W-1:0] next_limit;

  assign rcSource = !mode.srcXtal;

  always_ff @(posedge clk)
  begin
    if (reset || anyReset)
      enabled <= PERMANENT_WDT;
    else if (refreshStrobe && !globalReset)
      enabled <= 1'b1;
  end

  always_comb
  begin
    if (PERMANENT_WDT && rcSource)
      modeAllows = 1'b1;
    else if (stopMode)
      modeAllows = mode.runStop && rcSource;
    else if (haltMode)
      modeAllows = mode.runHalt;
    else
      modeAllows = 1'b1;
  end

  always_comb
  begin
    if (rcSource)
    begin
      unique case (mode.timeSel)
        2'h0: next_limit = wdl_pkg::CNT_W'(RC_TICKS_0);
        2'h1: next_limit = wdl_pkg::CNT_W'(RC_TICKS_1);
        2'h2: next_limit = wdl_pkg::CNT_W'(RC_TICKS_2);
        2'h3: next_limit = wdl_pkg::CNT_W'(RC_TICKS_3);
      endcase
    end
    else
    begin
      unique case (mode.timeSel)
        2'h0: next_limit = wdl_pkg::CNT_W'(wdl_pkg::SCLK_TIMEOUT_0);
        2'h1: next_limit = wdl_pkg::CNT_W'(wdl_pkg::SCLK_TIMEOUT_1);
        2'h2: next_limit = wdl_pkg::CNT_W'(wdl_pkg::SCLK_TIMEOUT_2);
        2'h3: next_limit = wdl_pkg::CNT_W'(wdl_pkg::SCLK_TIMEOUT_3);
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      limit <= wdl_pkg::CNT_W'(wdl_pkg::SCLK_TIMEOUT_0);
    else
      limit <= next_limit;
  end

  // Crystal source ticks every system clock; RC ticks on its rising edges
  assign advance = enabled && modeAllows && !globalReset
    && (rcSource ? rcTick : 1'b1);

  wdl_counter #(
    .CNT_W(wdl_pkg::CNT_W)
  ) u_counter (
    .clk(clk),
    .reset(reset),
    .restart(refreshStrobe || anyReset || globalReset || modeAccepted),
    .advance(advance),
    .limit(limit),
    .expired(wdtExpired)
  );

  // ---------------------------------------------------------------
  // Interrupt status and mask
  // ---------------------------------------------------------------
  logic [wdl_pkg::EV_W-1:0] events;
  logic [wdl_pkg::EV_W-1:0] irqStat;
  logic [wdl_pkg::EV_W-1:0] irqMask;
  logic lowPrev;

  always_ff @(posedge clk)
  begin
    if (reset)
      lowPrev <= 1'b0;
    else
      lowPrev <= lowSync;
  end

  always_comb
  begin
    events = '0;
    events[wdl_pkg::EV_TIMEOUT] = wdtExpired;
    events[wdl_pkg::EV_LOWV] = lowSync && !lowPrev;
    events[wdl_pkg::EV_REFUSED] = modeRefused;
  end

  // Set wins over a same-cycle write-one clear
  always_ff @(posedge clk)
  begin
    if (reset)
      irqStat <= '0;
    else if (writeIrqStat)
      irqStat <= (irqStat & ~dat_i[wdl_pkg::EV_W-1:0]) | events;
    else
      irqStat <= irqStat | events;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      irqMask <= '0;
    else if (writeIrqMask)
      irqMask <= dat_i[wdl_pkg::EV_W-1:0];
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      irq <= 1'b0;
    else
      irq <= |(irqStat & irqMask);
  end

  // ---------------------------------------------------------------
  // Bus answer
  // ---------------------------------------------------------------
  logic [wdl_pkg::WB_DW-1:0] next_rdata;

  always_comb
  begin
    next_rdata = '0;
    unique case (wordIdx)
      wdl_pkg::STATUS_IDX:
      begin
        next_rdata[wdl_pkg::ST_ENABLED] = enabled;
        next_rdata[wdl_pkg::ST_WINDOW] = (winState == wdl_pkg::WIN_OPEN);
        next_rdata[wdl_pkg::ST_LOCKED] = (winState == wdl_pkg::WIN_LOCKED);
        next_rdata[wdl_pkg::ST_LOWV] = lowSync;
        next_rdata[wdl_pkg::ST_POR] = porCountBusy;
        next_rdata[wdl_pkg::ST_XTAL] = mode.srcXtal;
      end
      wdl_pkg::IRQ_STAT_IDX: next_rdata[wdl_pkg::EV_W-1:0] = irqStat;
      wdl_pkg::IRQ_MASK_IDX: next_rdata[wdl_pkg::EV_W-1:0] = irqMask;
      default: next_rdata = '0; // Mode register reads as zero
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      ack_o <= 1'b0;
      dat_o <= '0;
    end
    else
    begin
      ack_o <= busReq && !ack_o;
      dat_o <= (busReq && !ack_o && !we_i) ? next_rdata : '0;
    end
  end

endmodule // wdl_top

// [tb/watchdog_with_lock_config_test.sv]
`timescale 1ns/1ps
module watchdog_with_lock_config_test;
  localparam int POR = 20;
  localparam int RC2 = 16;
  logic clk, reset, cyc, stb, we, ack, refreshStrobe, firstInstr, stopRecovery;
  logic haltMode, stopMode, rcClk, lowVoltage, resetPinIn, resetPinOut, resetPinOe;
  logic globalReset, irq;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] dat, datOut, q;
  logic [2:0] rcDiv;
  int n_errors, samples_checked, n;

  wdl_top #(.POR_CYCLES(POR), .RC_TICKS_0(8), .RC_TICKS_1(10), .RC_TICKS_2(RC2),
    .RC_TICKS_3(24)) u_dut (.clk(clk), .reset(reset), .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat), .dat_o(datOut), .ack_o(ack),
    .refreshStrobe(refreshStrobe), .firstInstr(firstInstr), .stopRecovery(stopRecovery),
    .haltMode(haltMode), .stopMode(stopMode), .rcClk(rcClk), .lowVoltage(lowVoltage),
    .resetPinIn(resetPinIn), .resetPinOut(resetPinOut), .resetPinOe(resetPinOe),
    .globalReset(globalReset), .irq(irq));

  // Open-drain reset pin with pull-up
  assign resetPinIn = !resetPinOe;

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // RC oscillator at one eighth of the system clock
  always @(posedge clk)
  begin
    rcDiv <= rcDiv + 3'h1;
    rcClk <= rcDiv[2];
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    samples_checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH %0t %s", $time, msg);
    end
  endtask

  task automatic wb(input logic w, input logic [5:0] idx, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= {idx, 2'b00}; dat <= d; sel <= 4'h1;
    do
    begin
      @(posedge clk);
    end
    while (ack !== 1'b1);
    q = datOut;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    chk({31'h0, ack}, 32'h1, "bus answer missing");
  endtask

  task automatic pulse(input int which);
    @(posedge clk);
    if (which == 0) refreshStrobe <= 1'b1;
    if (which == 1) firstInstr <= 1'b1;
    if (which == 2) stopRecovery <= 1'b1;
    @(posedge clk);
    refreshStrobe <= 1'b0; firstInstr <= 1'b0; stopRecovery <= 1'b0;
  endtask

  task automatic waitGr(input logic lvl, input int lim);
    n = 0;
    while (globalReset !== lvl && n < lim)
    begin
      @(posedge clk);
      n++;
    end
    chk({31'h0, globalReset}, {31'h0, lvl}, "reset level not reached");
  endtask

  task automatic t_por;
    waitGr(1'b0, 100);
    chk({31'h0, n >= POR}, 32'h1, "power-on time short");
    chk({31'h0, resetPinOe}, 32'h0, "pin still driven");
  endtask

  task automatic t_regs;
    wb(1'b0, wdl_pkg::MODE_IDX, 32'h0);
    chk(q, 32'h0, "mode register readable");
    wb(1'b0, 6'h3f, 32'h0);
    chk(q, 32'h0, "unmapped read not zero");
    wb(1'b1, wdl_pkg::IRQ_MASK_IDX, 32'h4);
    wb(1'b0, wdl_pkg::IRQ_MASK_IDX, 32'h0);
    chk(q, 32'h4, "mask readback");
    wb(1'b0, wdl_pkg::STATUS_IDX, 32'h0);
    chk(q & 32'h23, 32'h0, "status after reset");
  endtask

  task automatic t_default;
    repeat (RC2 * 12) @(posedge clk);
    chk({31'h0, globalReset}, 32'h0, "expiry without refresh");
    pulse(0);
    waitGr(1'b1, 400);
    chk({31'h0, n >= RC2 * 8 - 8 && n <= RC2 * 8 + 16}, 32'h1, "default timeout");
    waitGr(1'b0, 100);
  endtask

  task automatic t_window;
    pulse(1);
    wb(1'b1, wdl_pkg::MODE_IDX, 32'h10);
    pulse(2);
    wb(1'b0, wdl_pkg::STATUS_IDX, 32'h0);
    chk(q & 32'h20, 32'h20, "crystal source lost");
    pulse(0);
    repeat (100) @(posedge clk);
    chk({31'h0, globalReset}, 32'h0, "early expiry");
    pulse(0);
    waitGr(1'b1, 300);
    chk({31'h0, n >= 127 && n <= 132}, 32'h1, "crystal timeout");
    waitGr(1'b0, 100);
    wb(1'b0, wdl_pkg::STATUS_IDX, 32'h0);
    chk(q & 32'h21, 32'h0, "mode not restored");
  endtask

  task automatic t_lock;
    wb(1'b1, wdl_pkg::IRQ_MASK_IDX, 32'h4);
    pulse(1);
    repeat (62) @(posedge clk);
    wb(1'b1, wdl_pkg::MODE_IDX, 32'h10);
    wb(1'b0, wdl_pkg::STATUS_IDX, 32'h0);
    chk(q & 32'h20, 32'h0, "locked write took effect");
    chk({31'h0, irq}, 32'h1, "refused write irq");
    wb(1'b1, wdl_pkg::IRQ_STAT_IDX, 32'h4);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h0, "irq not cleared");
  endtask

  task automatic t_lowv;
    lowVoltage <= 1'b1;
    repeat (6) @(posedge clk);
    chk({31'h0, globalReset}, 32'h1, "no reset on low supply");
    wb(1'b0, wdl_pkg::STATUS_IDX, 32'h0);
    chk(q & 32'h8, 32'h8, "low supply status");
    lowVoltage <= 1'b0;
    waitGr(1'b0, 100);
  endtask

  task automatic t_halt;
    pulse(1);
    wb(1'b1, wdl_pkg::MODE_IDX, 32'h18);
    stopMode <= 1'b1;
    pulse(0);
    repeat (150) @(posedge clk);
    chk({31'h0, globalReset}, 32'h0, "counted in STOP on crystal");
    stopMode <= 1'b0;
    haltMode <= 1'b1;
    pulse(0);
    repeat (150) @(posedge clk);
    chk({31'h0, globalReset}, 32'h0, "counted in HALT with bit clear");
    haltMode <= 1'b0;
    pulse(0);
    waitGr(1'b1, 300);
    chk({31'h0, n >= 127 && n <= 132}, 32'h1, "timeout after HALT");
    waitGr(1'b0, 100);
  endtask

  task automatic results;
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial
  begin
    #(50 * 20000);
    n_errors++;
    results();
  end

  initial
  begin
    {reset, cyc, stb, we, refreshStrobe, firstInstr, stopRecovery} = 7'h40;
    {haltMode, stopMode, rcClk, lowVoltage, rcDiv} = 7'h0;
    adr = 8'h0; sel = 4'h0; dat = 32'h0; n_errors = 0; samples_checked = 0;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    t_por();
    t_regs();
    t_default();
    t_window();
    t_lock();
    t_lowv();
    t_halt();
    results();
  end
endmodule // watchdog_with_lock_config_test

// [tb/wdl_top_monitor.sv]
`timescale 1ns/1ps
module wdl_top_monitor #(
  parameter int POR_CYCLES = 20
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic [wdl_pkg::WB_DW-1:0] dat_o,
  input wire logic ack_o,
  input wire logic refreshStrobe,
  input wire logic lowVoltage,
  input wire logic resetPinIn,
  input wire logic resetPinOut,
  input wire logic resetPinOe,
  input wire logic globalReset,
  input wire logic irq
);
  // ----------------------------------------------------------------
  // Length of each reset pin drive
  // ----------------------------------------------------------------
  logic [19:0] oeRun;
  always_ff @(posedge clk)
  begin
    if (reset || !resetPinOe)
      oeRun <= 20'h0;
    else if (oeRun != 20'hfffff)
      oeRun <= oeRun + 20'h1;
  end

  sequence sQuietSupply;
    (!lowVoltage && resetPinIn) [*3];
  endsequence

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  a_ack_answer: assert property (@(posedge clk) disable iff (reset)
    cyc_i && stb_i && !ack_o |=> ack_o) else $error("bus request not answered");
  a_ack_pulse: assert property (@(posedge clk) disable iff (reset)
    ack_o |=> !ack_o) else $error("ack longer than one cycle");
  a_data_idle: assert property (@(posedge clk) disable iff (reset)
    !ack_o |-> dat_o == '0) else $error("read data outside ack");
  a_lowv_reset: assert property (@(posedge clk) disable iff (reset)
    lowVoltage [*5] |-> globalReset) else $error("low supply without reset");
  a_pin_open_drain: assert property (@(posedge clk) disable iff (reset)
    resetPinOut == 1'b0) else $error("reset pin driven high");
  a_reset_state: assert property (@(posedge clk)
    reset |=> globalReset && resetPinOe && !irq) else $error("bad state in reset");
  a_refresh_holds: assert property (@(posedge clk) disable iff (reset)
    sQuietSupply ##0 (refreshStrobe && !globalReset) |=> !globalReset [*2])
    else $error("reset right after refresh");
  a_por_length: assert property (@(posedge clk) disable iff (reset)
    $fell(resetPinOe) |-> oeRun >= POR_CYCLES) else $error("reset pin pulse too short");
endmodule // wdl_top_monitor

bind wdl_top wdl_top_monitor #(.POR_CYCLES(POR_CYCLES)) u_mon (
  .clk(clk),
  .reset(reset),
  .cyc_i(cyc_i),
  .stb_i(stb_i),
  .dat_o(dat_o),
  .ack_o(ack_o),
  .refreshStrobe(refreshStrobe),
  .lowVoltage(lowVoltage),
  .resetPinIn(resetPinIn),
  .resetPinOut(resetPinOut),
  .resetPinOe(resetPinOe),
  .globalReset(globalReset),
  .irq(irq)
);
